// ---- hdl/src_core.sv ----
`timescale 1ns/10ps
`include "src_regs.svh"
module src_core
   import src_pkg::*;
#(
   parameter int DEPTH   = `SRC_RAM_DEPTH,
   parameter int LOOP_KP = `SRC_LOOP_KP,
   parameter int LOOP_KI = `SRC_LOOP_KI
)
(
   input  wire logic           ref_clk,
   input  wire logic           reset_n,
   input  wire logic           clk_en,
   input  wire logic           in_frame,
   input  wire logic [23:0]    in_left,
   input  wire logic [23:0]    in_right,
   input  wire logic           out_frame,
   input  wire logic           delay_length_select,
   input  wire logic           mute_in,
   output logic [23:0]         out_left_r,
   output logic [23:0]         out_right_r,
   output logic                out_valid_r,
   output logic                decimating
);
   localparam int AW  = $clog2(DEPTH);
   localparam int FR  = `SRC_SERVO_FRAC;
   localparam int PW  = AW + FR;
   localparam int PB  = `SRC_PHASE_BITS;
   localparam int RW  = PB + `SRC_TAP_BITS;
   localparam src_ratio_type ONE = `SRC_RATIO_ONE;
   // least inverse ratio so that taps fit in depth less offset
   localparam int SPAN_S = DEPTH - `SRC_OFS_SHORT;
   localparam int SPAN_L = DEPTH - `SRC_OFS_LONG;
   localparam int NUM    = `SRC_TAPS * (1 << `SRC_RATIO_FRAC);
   localparam src_ratio_type INV_MIN_S = 13'((NUM + SPAN_S - 1) / SPAN_S);
   localparam src_ratio_type INV_MIN_L = 13'((NUM + SPAN_L - 1) / SPAN_L);

   if ((1 << AW) != DEPTH || SPAN_L < `SRC_TAPS)
      $error("src_core: DEPTH must be a power of two above offset plus taps");
   if (LOOP_KP < 1 || LOOP_KI <= LOOP_KP || LOOP_KI > FR)
      $error("src_core: servo shifts out of range");

   // gain or ratio scaling of a sample, sh fraction bits in g
   function automatic src_sample_type scale(src_sample_type s,
                                            logic [12:0]    g,
                                            int             sh);
      logic signed [37:0] p;
      p = s * $signed({1'b0, g});
      return src_sample_type'(p >>> sh);
   endfunction : scale

   // drop the coefficient fraction and clip to 24 bits
   function automatic logic [23:0] sat(input logic signed [49:0] a);
      logic signed [49:0] s;
      s = a >>> `SRC_COEF_FRAC;
      if (s > 50'sh7fffff)
         return 24'h7fffff;
      if (s < -50'sh800000)
         return 24'h800000;
      return s[23:0];
   endfunction : sat

   ////////////////////////////////////////////////////////////////////////
   // frame strobe synchronisers, stage 0 feeds stage 1 only
   logic [2:0] in_sync_r;
   logic [2:0] out_sync_r;
   wire in_tick  = clk_en & in_sync_r[1] & ~in_sync_r[2];
   wire out_tick = clk_en & out_sync_r[1] & ~out_sync_r[2];

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         in_sync_r  <= 3'h0;
         out_sync_r <= 3'h0;
      end
      else if (clk_en)
      begin
         in_sync_r  <= {in_sync_r[1:0], in_frame};
         out_sync_r <= {out_sync_r[1:0], out_frame};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // rate ratio and its effective inverse
   src_ratio_type dec_ratio;
   src_ratio_type inv_ratio;

   src_ratio u_ratio (
      .ref_clk     (ref_clk),
      .reset_n     (reset_n),
      .in_tick     (in_tick),
      .out_tick    (out_tick),
      .dec_ratio_r (dec_ratio),
      .inv_ratio_r (inv_ratio)
   );

   wire                decim   = dec_ratio > ONE;
   wire src_ratio_type inv_min = delay_length_select ? INV_MIN_S : INV_MIN_L;
   // clamp keeps the lengthened convolution inside the RAM
   wire src_ratio_type inv_eff = !decim ? ONE :
      ((inv_ratio < inv_min) ? inv_min : inv_ratio);
   assign decimating = decim;

   ////////////////////////////////////////////////////////////////////////
   // soft mute counter, starts at full attenuation
   logic [`SRC_MUTE_BITS-1:0] mute_cnt_r;
   wire mute_floor = (mute_cnt_r == 12'h000);
   wire mute_top   = (mute_cnt_r == 12'hfff);
   wire [11:0] mute_nxt = mute_in ?
      (mute_floor ? mute_cnt_r : mute_cnt_r - 12'h001) :
      (mute_top ? mute_cnt_r : mute_cnt_r + 12'h001);
   wire [12:0] gain = mute_top ? `SRC_MUTE_UNITY : {1'b0, mute_cnt_r};

   ////////////////////////////////////////////////////////////////////////
   // input scaling and write address
   logic [AW-1:0] wr_cnt_r;
   wire  [AW-1:0] ofs = delay_length_select ? AW'(`SRC_OFS_SHORT) :
                                              AW'(`SRC_OFS_LONG);
   wire  [AW-1:0] wr_addr = wr_cnt_r + ofs;
   wire src_sample_type wr_l =
      scale(scale(in_left, gain, 12), inv_eff, 8);
   wire src_sample_type wr_r =
      scale(scale(in_right, gain, 12), inv_eff, 8);

   // sample RAM, one word per channel per input frame
   src_sample_type ram_l [DEPTH];
   src_sample_type ram_r [DEPTH];

   always_ff @(posedge ref_clk)
   begin
      if (in_tick)
      begin
         ram_l[wr_addr] <= wr_l;
         ram_r[wr_addr] <= wr_r;
      end
   end

   // input-rate counter and mute step, once per input frame
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_cnt_r   <= '0;
         mute_cnt_r <= '0;
      end
      else if (in_tick)
      begin
         wr_cnt_r   <= wr_cnt_r + AW'(1);
         mute_cnt_r <= mute_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // servo ramp: phase in RAM words with FR fraction bits; the step is
   // averaged over many input frames, so strobe jitter is filtered out
   logic [PW-1:0] phase_r;
   logic [31:0]   step_r;
   wire signed [PW-1:0] ph_err =
      $signed({wr_cnt_r + AW'(1), {FR{1'b0}}} - phase_r);
   wire [PW-1:0] ph_adv    = phase_r + PW'(step_r);
   wire [PW-1:0] phase_nxt = in_tick ?
      ph_adv + PW'(ph_err >>> LOOP_KP) : ph_adv;
   wire [31:0]   step_nxt  = in_tick ?
      step_r + 32'(ph_err >>> LOOP_KI) : step_r;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase_r <= '0;
         step_r  <= `SRC_STEP_INIT;
      end
      else if (clk_en)
      begin
         phase_r <= phase_nxt;
         step_r  <= step_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start pointers; a ramp ahead of the writes is pulled back to them
   wire [AW-1:0] ph_int    = phase_r[PW-1 -: AW];
   wire [AW-1:0] ph_lag    = wr_cnt_r - ph_int;
   wire [AW-1:0] start_ram = ph_lag[AW-1] ? wr_cnt_r : ph_int;
   wire [PB-1:0] start_frac = phase_r[FR-1 -: PB];
   wire [32:0]   frac_scaled = start_frac * inv_eff;
   wire [RW-1:0] start_rom  = RW'(frac_scaled >> 8);
   wire [RW-1:0] step_sel   = RW'({inv_eff, 12'h000});

   ////////////////////////////////////////////////////////////////////////
   // convolution engine
   src_state_type     state_r;
   src_state_type     state_nxt;
   logic [AW-1:0]     rd_ptr_r;
   logic [RW-1:0]     rom_r;
   logic [RW-1:0]     rom_step_r;
   logic              conv_dec_r;
   logic [9:0]        tap_cnt_r;
   logic signed [49:0] acc_l_r;
   logic signed [49:0] acc_r_r;
   logic signed [15:0] coef;

   src_coef #(
      .COEF_W (16)
   ) u_coef (
      .rom_addr (rom_r),
      .coef     (coef)
   );

   wire start  = (state_r == SRC_IDLE) & out_tick;
   wire mac_l  = clk_en & (state_r == SRC_MAC_L);
   wire mac_r  = clk_en & (state_r == SRC_MAC_R);
   wire [RW:0] rom_sum  = {1'b0, rom_r} + {1'b0, rom_step_r};
   wire        last_tap = rom_sum[RW];
   // one multiplier serves left then right on each tap
   wire signed [23:0] rd_smp = (state_r == SRC_MAC_L) ?
      ram_l[rd_ptr_r] : ram_r[rd_ptr_r];
   wire signed [39:0] prod    = rd_smp * coef;
   wire signed [49:0] acc_sel = (state_r == SRC_MAC_L) ? acc_l_r : acc_r_r;
   wire signed [49:0] acc_sum = acc_sel + 50'(prod);

   wire [AW-1:0] rd_nxt  = start ? start_ram :
      (mac_r ? rd_ptr_r - AW'(1) : rd_ptr_r);
   wire [RW-1:0] rom_nxt = start ? start_rom :
      (mac_r ? rom_sum[RW-1:0] : rom_r);
   wire signed [49:0] accl_nxt = start ? 50'sh0 : (mac_l ? acc_sum : acc_l_r);
   wire signed [49:0] accr_nxt = start ? 50'sh0 : (mac_r ? acc_sum : acc_r_r);
   wire [9:0] tap_nxt = start ? 10'h000 : tap_cnt_r + {9'h000, mac_r};

   // state sequence: an output strobe while busy is not taken
   always_comb
   begin
      unique case (state_r)
         SRC_IDLE  : state_nxt = out_tick ? SRC_MAC_L : SRC_IDLE;
         SRC_MAC_L : state_nxt = SRC_MAC_R;
         SRC_MAC_R : state_nxt = last_tap ? SRC_DONE : SRC_MAC_L;
         SRC_DONE  : state_nxt = SRC_IDLE;
         default   : state_nxt = SRC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r    <= SRC_IDLE;
         rd_ptr_r   <= '0;
         rom_r      <= '0;
         rom_step_r <= '0;
         conv_dec_r <= 1'b0;
         tap_cnt_r  <= 10'h000;
         acc_l_r    <= 50'sh0;
         acc_r_r    <= 50'sh0;
      end
      else if (clk_en)
      begin
         state_r    <= state_nxt;
         rd_ptr_r   <= rd_nxt;
         rom_r      <= rom_nxt;
         rom_step_r <= start ? step_sel : rom_step_r;
         conv_dec_r <= start ? decim : conv_dec_r;
         tap_cnt_r  <= tap_nxt;
         acc_l_r    <= accl_nxt;
         acc_r_r    <= accr_nxt;
      end
   end

   // results and one-cycle valid
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         out_left_r  <= 24'h000000;
         out_right_r <= 24'h000000;
         out_valid_r <= 1'b0;
      end
      else if (clk_en)
      begin
         out_valid_r <= (state_r == SRC_DONE);
         if (state_r == SRC_DONE)
         begin
            out_left_r  <= sat(acc_l_r);
            out_right_r <= sat(acc_r_r);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_ONE_CONV: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      start |=> state_r == SRC_MAC_L && rd_ptr_r == $past(start_ram))
      else $error("convolution did not start from the ramp pointer");

   AST_TAPS64: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (state_r == SRC_DONE && !conv_dec_r) |-> tap_cnt_r == 10'h040)
      else $error("upsampling convolution not 64 taps");

   AST_RAM_DEC: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      mac_r |=> rd_ptr_r == $past(rd_ptr_r) - AW'(1))
      else $error("RAM pointer did not step down by one");

   AST_ROM_STEP: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (mac_r && !conv_dec_r) |=>
         rom_r == $past(rom_r) + RW'(1 << `SRC_PHASE_BITS))
      else $error("ROM pointer did not advance by 2^20");

   AST_SHARED: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      // words not yet written hold no value; compare all four states
      mac_l |=> state_r == SRC_MAC_R && acc_l_r === $past(acc_sum))
      else $error("left tap not followed by right tap");

   AST_START_FRAC: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (start && !decim) |=> rom_r == RW'($past(start_frac)))
      else $error("ROM start is not the ramp fraction");

   AST_NO_OVERLAP: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      start |-> AW'(wr_addr - start_ram) >= ofs)
      else $error("read start inside the write offset");

   AST_MUTE_STEP: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (in_tick && mute_in && !mute_floor) |=>
         mute_cnt_r == $past(mute_cnt_r) - 12'h001)
      else $error("mute counter did not step down");
endmodule : src_core

// ---- hdl/src_regs.svh ----
`ifndef SRC_REGS_SVH
`define SRC_REGS_SVH
// Overview of operation
// - output picks one of 2^20 polyphase positions
// - one 64-tap convolution per output period when upsampling
// - coefficient ROM subset, high-order interpolated
// - output instant resolved by averaging coarse measurements
// - decimation stretches coefficients and lengthens convolution
// - decimation scales input by output/input ratio
// - soft mute gain applied before RAM write
// - 512-word sample RAM per channel
// - write offset 16 when select high, else 64
// - offset keeps read pointer off write address
// - decimation bounded by (depth minus offset)/64
// - input counter feeds write address and servo ramp
// - servo integer/fraction give RAM/ROM start pointers
// - decimating divides fraction by input/output ratio
// - ratio feeds coefficients, length and input scaling
// - servo tracks input rate, rejects input strobe jitter
// - per tap: RAM minus one, ROM plus step
// - one MAC shared by left and right
// - ratio one when upsampling; hysteresis two counts
// - 12-bit mute counter stepped per input frame

// clock
`define SRC_CLK_HZ      20000000
// polyphase resolution and filter length
`define SRC_PHASE_BITS  20
`define SRC_TAPS        64
`define SRC_TAP_BITS    6
// sample RAM and write offsets
`define SRC_RAM_DEPTH   512
`define SRC_OFS_SHORT   16
`define SRC_OFS_LONG    64
// soft mute
`define SRC_MUTE_BITS   12
`define SRC_MUTE_UNITY  13'h1000
// rate ratio, unsigned with 8 fraction bits
`define SRC_RATIO_FRAC  8
`define SRC_RATIO_ONE   13'h100
`define SRC_HYST        13'h002
// coefficient table
`define SRC_COEF_FRAC   17
`define SRC_COEF_PEAK   3840
// servo loop
`define SRC_SERVO_FRAC  36
`define SRC_LOOP_KP     4
`define SRC_LOOP_KI     14
`define SRC_STEP_INIT   32'h09d2_8b1c
`endif

// ---- hdl/src_pkg.sv ----
package src_pkg;
   typedef logic signed [23:0] src_sample_type;
   typedef logic [12:0]        src_ratio_type;
   typedef enum logic [3:0] {
      SRC_IDLE  = 4'b0001,
      SRC_MAC_L = 4'b0010,
      SRC_MAC_R = 4'b0100,
      SRC_DONE  = 4'b1000
   } src_state_type;
endpackage : src_pkg

// ---- hdl/src_coef.sv ----
`timescale 1ns/10ps
`include "src_regs.svh"
module src_coef
   import src_pkg::*;
#(
   parameter int COEF_W = 16
)
(
   input  wire logic [25:0]              rom_addr,
   output logic signed [COEF_W-1:0]      coef
);
   localparam int NPT = 128;

   if (COEF_W < 13)
      $error("src_coef: COEF_W too narrow for the kernel peak");

   // smooth window kernel value of stored point i, zero outside the span
   function automatic longint kern(input int i);
      longint x;
      x = longint'(i) - 64;
      if (x > 64)
         return 0;
      return (longint'(`SRC_COEF_PEAK) * (4096 - x * x) * (4096 - x * x))
             >>> 24;
   endfunction : kern

   ////////////////////////////////////////////////////////////////////////
   // constant table: two stored points per tap only
   logic signed [COEF_W-1:0] tbl [NPT+3];
   for (genvar g = 0; g < NPT + 3; g++)
   begin : g_rom
      assign tbl[g] = COEF_W'(kern(g));
   end

   ////////////////////////////////////////////////////////////////////////
   // quadratic interpolation over three neighbouring points
   wire        [7:0]  i0 = {1'b0, rom_addr[25:19]};
   wire signed [COEF_W-1:0] y0 = tbl[i0];
   wire signed [COEF_W-1:0] y1 = tbl[i0 + 8'h01];
   wire signed [COEF_W-1:0] y2 = tbl[i0 + 8'h02];
   wire signed [17:0] d1 = y1 - y0;
   wire signed [17:0] d2 = y2 - (y1 <<< 1) + y0;
   wire signed [10:0] f  = {1'b0, rom_addr[18:9]};
   // f * (f - 1), fraction one is 1024; 11'sh400 is minus 1024
   wire signed [21:0] ff = f * (f + 11'sh400);
   wire signed [39:0] t1 = d1 * f;
   wire signed [39:0] t2 = d2 * ff;
   assign coef = COEF_W'(y0 + (t1 >>> 10) + (t2 >>> 21));
endmodule : src_coef

// ---- hdl/src_ratio.sv ----
`timescale 1ns/10ps
`include "src_regs.svh"
module src_ratio
   import src_pkg::*;
(
   input  wire logic           ref_clk,
   input  wire logic           reset_n,
   input  wire logic           in_tick,
   input  wire logic           out_tick,
   output src_ratio_type       dec_ratio_r,
   output src_ratio_type       inv_ratio_r
);
   localparam src_ratio_type ONE = `SRC_RATIO_ONE;

   // saturating event count
   function automatic src_ratio_type bump(src_ratio_type c, logic t);
      return (t && c != 13'h1fff) ? c + 13'h0001 : c;
   endfunction : bump

   // clamp to one on the held side, then move only past the hysteresis
   function automatic src_ratio_type hyst(src_ratio_type old,
                                          src_ratio_type cand,
                                          logic          up);
      src_ratio_type lim;
      src_ratio_type diff;
      lim  = up ? ((cand < ONE) ? ONE : cand) : ((cand > ONE) ? ONE : cand);
      diff = (lim > old) ? lim - old : old - lim;
      return (diff > `SRC_HYST) ? lim : old;
   endfunction : hyst

   ////////////////////////////////////////////////////////////////////////
   // 256-period windows: input ticks per output window and vice versa
   logic [7:0]    out_win_r;
   logic [7:0]    in_win_r;
   src_ratio_type in_cnt_r;
   src_ratio_type out_cnt_r;
   wire out_wrap = out_tick & (out_win_r == 8'hff);
   wire in_wrap  = in_tick & (in_win_r == 8'hff);
   wire src_ratio_type in_cand  = bump(in_cnt_r, in_tick);
   wire src_ratio_type out_cand = bump(out_cnt_r, out_tick);

   // ratio registers, reset to one
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         out_win_r   <= 8'h00;
         in_win_r    <= 8'h00;
         in_cnt_r    <= 13'h0000;
         out_cnt_r   <= 13'h0000;
         dec_ratio_r <= ONE;
         inv_ratio_r <= ONE;
      end
      else
      begin
         out_win_r <= out_win_r + {7'h00, out_tick};
         in_win_r  <= in_win_r + {7'h00, in_tick};
         in_cnt_r  <= out_wrap ? 13'h0000 : in_cand;
         out_cnt_r <= in_wrap ? 13'h0000 : out_cand;
         if (out_wrap)
            dec_ratio_r <= hyst(dec_ratio_r, in_cand, 1'b1);
         if (in_wrap)
            inv_ratio_r <= hyst(inv_ratio_r, out_cand, 1'b0);
      end
   end

   AST_RATIO_FLOOR: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      dec_ratio_r >= ONE && inv_ratio_r <= ONE)
      else $error("ratio left its held range");

   AST_RATIO_HYST: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      $changed(dec_ratio_r) |->
         ((dec_ratio_r > $past(dec_ratio_r)) ?
            dec_ratio_r - $past(dec_ratio_r) :
            $past(dec_ratio_r) - dec_ratio_r) > 13'h002)
      else $error("ratio moved by two counts or less");
endmodule : src_ratio

// ---- verif/src_port_model.sv ----
`timescale 1ns/10ps
// serial port stand-in: frame strobes and samples for the core
module src_port_model
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] in_period,
   input  wire logic [15:0] out_period,
   input  wire logic [23:0] next_left,
   input  wire logic [23:0] next_right,
   output logic             in_frame,
   output logic [23:0]      in_left,
   output logic [23:0]      in_right,
   output logic             out_frame,
   output int               in_frames,
   output int               out_frames
);
   int in_cnt;
   int out_cnt;

   ////////////////////////////////////////////////////////////////////////
   // strobes move on the falling edge; samples stay put a whole frame
   always @(negedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         in_cnt     <= 0;
         out_cnt    <= 0;
         in_frame   <= 1'b0;
         out_frame  <= 1'b0;
         in_left    <= 24'h0;
         in_right   <= 24'h0;
         in_frames  <= 0;
         out_frames <= 0;
      end
      else
      begin
         if (in_cnt >= in_period - 1)
         begin
            in_cnt    <= 0;
            in_frame  <= 1'b1;
            in_left   <= next_left;
            in_right  <= next_right;
            in_frames <= in_frames + 1;
         end
         else
         begin
            in_cnt <= in_cnt + 1;
            if (in_cnt + 1 >= in_period / 2)
               in_frame <= 1'b0;
         end
         if (out_cnt >= out_period - 1)
         begin
            out_cnt    <= 0;
            out_frame  <= 1'b1;
            out_frames <= out_frames + 1;
         end
         else
         begin
            out_cnt <= out_cnt + 1;
            if (out_cnt + 1 >= out_period / 2)
               out_frame <= 1'b0;
         end
      end
   end
endmodule : src_port_model

// ---- verif/test_async_sample_rate_converter_core.sv ----
`timescale 1ns/10ps
module test_async_sample_rate_converter_core
   import src_pkg::*;
;
   localparam int CYC_LIMIT   = 100000;
   localparam int MIN_DEC_GAP = 2 * 2 * 64 + 2;
   logic        ref_clk;
   logic        reset_n;
   logic        clk_en;
   logic        delay_length_select;
   logic        mute_in;
   logic        in_frame;
   logic        out_frame;
   logic [23:0] in_left;
   logic [23:0] in_right;
   logic [23:0] out_left_r;
   logic [23:0] out_right_r;
   logic        out_valid_r;
   logic        decimating;
   logic [15:0] in_period;
   logic [15:0] out_period;
   logic [23:0] next_left;
   logic [23:0] next_right;
   logic        prev_v;
   logic        chk_zero;
   logic        chk_gap;
   logic [23:0] save;
   int          in_frames;
   int          out_frames;
   int          out_base;
   int          n_errors;
   int          tests_run;
   int          cyc;
   int          n_valid;
   int          nv0;
   int          no0;
   int          i;
   time         last_t;

   ////////////////////////////////////////////////////////////////////////
   // core with a quicker servo, and the serial port stand-in
   src_core #(.DEPTH(512), .LOOP_KP(2), .LOOP_KI(8)) uut
   (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
      .in_frame(in_frame), .in_left(in_left), .in_right(in_right),
      .out_frame(out_frame), .delay_length_select(delay_length_select),
      .mute_in(mute_in), .out_left_r(out_left_r),
      .out_right_r(out_right_r), .out_valid_r(out_valid_r),
      .decimating(decimating)
   );
   src_port_model u_port
   (
      .ref_clk(ref_clk), .reset_n(reset_n), .in_period(in_period),
      .out_period(out_period), .next_left(next_left),
      .next_right(next_right), .in_frame(in_frame), .in_left(in_left),
      .in_right(in_right), .out_frame(out_frame), .in_frames(in_frames),
      .out_frames(out_frames)
   );

   ////////////////////////////////////////////////////////////////////////
   // clock at 20 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : check

   task final_report;
      if (n_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   // let n input frames pass; random samples and output jitter on request
   task run_frames(input int n, input logic rnd);
      int stop;
      stop = in_frames + n;
      while (in_frames < stop)
      begin
         @(negedge ref_clk);
         if (rnd)
         begin
            next_left  = 24'($urandom);
            next_right = 24'($urandom);
            out_period = 16'(out_base - 2 + $urandom % 5);
         end
      end
   endtask : run_frames

   task wait_valid(input int n, input int limit);
      nv0 = n_valid;
      for (i = 0; i < limit && n_valid < nv0 + n; i++)
         @(negedge ref_clk);
   endtask : wait_valid

   ////////////////////////////////////////////////////////////////////////
   // hang guard
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == CYC_LIMIT)
      begin
         n_errors++;
         $display("[ERR] %0t timeout", $time);
         final_report();
      end
   end

   // result pulses: width, spacing, muted contents
   always @(posedge ref_clk)
      if (reset_n === 1'b1 && clk_en === 1'b1)
      begin
         if (out_valid_r === 1'b1)
         begin
            check(prev_v !== 1'b1, "valid wider than a cycle");
            if (chk_zero)
               check(out_left_r === 24'h0 && out_right_r === 24'h0,
                     "muted output not zero");
            if (chk_gap)
               check(($time - last_t) / 50 > MIN_DEC_GAP,
                     "convolution not lengthened");
            last_t = $time;
            n_valid++;
         end
         prev_v = out_valid_r;
      end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {reset_n, chk_zero, chk_gap, prev_v} = 4'h0;
      {clk_en, mute_in, delay_length_select} = 3'h7;
      {n_errors, tests_run, cyc, n_valid, last_t} = 0;
      in_period  = 16'd200;
      out_base   = 160;
      out_period = 16'd160;
      next_left  = 24'h0;
      next_right = 24'h0;
      void'($urandom(32'h0013));
      repeat (2) @(negedge ref_clk);
      check(out_valid_r === 1'b0 && out_left_r === 24'h0 &&
            decimating === 1'b0, "reset state");
      reset_n = 1'b1;
      // muted random stream, output faster than input; the read window
      // must lie wholly in written words before contents are judged
      run_frames(100, 1'b1);
      chk_zero = 1'b1;
      nv0 = n_valid;
      no0 = out_frames;
      run_frames(20, 1'b1);
      chk_zero = 1'b0;
      i = (out_frames - no0) - (n_valid - nv0);
      check(i >= -1 && i <= 1, "results per output frame");
      check(decimating === 1'b0, "decimating while upsampling");
      // unmute a constant input, freeze the clock enable midway
      mute_in    = 1'b0;
      next_left  = 24'h400000;
      next_right = 24'hc00000;
      run_frames(80, 1'b0);
      clk_en = 1'b0;
      save   = out_left_r;
      repeat (200) @(negedge ref_clk);
      check(out_left_r === save, "output moved while frozen");
      clk_en = 1'b1;
      run_frames(80, 1'b0);
      check($signed(out_left_r) > 0 && $signed(out_left_r) < 24'sh080000,
            "left ramp out of range");
      check($signed(out_right_r) < 0 && $signed(out_right_r) > -24'sh080000,
            "right ramp out of range");
      // input three times faster, muting again: longer convolution
      mute_in    = 1'b1;
      delay_length_select = 1'b0;
      in_period  = 16'd10;
      out_base   = 30;
      out_period = 16'd30;
      for (i = 0; i < 20000 && decimating !== 1'b1; i++)
         @(negedge ref_clk);
      check(decimating === 1'b1, "no decimation seen");
      // two full inverse-ratio windows before the run length is timed
      run_frames(600, 1'b0);
      wait_valid(2, 2000);
      chk_gap = 1'b1;
      wait_valid(3, 3000);
      chk_gap = 1'b0;
      check(n_valid >= nv0 + 3, "no results while decimating");
      // second reset in mid-run
      reset_n = 1'b0;
      @(negedge ref_clk);
      check(out_valid_r === 1'b0 && out_left_r === 24'h0 &&
            decimating === 1'b0, "mid-run reset");
      reset_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      final_report();
   end
endmodule : test_async_sample_rate_converter_core
